// >>> verilog/sbspc_pkg.sv
// package for the synchronous burst sram pin control block
// assumes one clock; the bus partner is logic on that same clock
// Function
// - address taken only on a strobe with all three chip selects active
// - two low captured address bits seed the two-bit burst counter
// - byte write needs byte write enable low plus each lane select low
// - global write low writes all four lanes, ignoring lane selects
// - burst counter steps on each selected non-load edge with burst step input low
// - selected only when select one low, two high, three low
// - chip selects looked at only on address loads, not burst cycles
// - processor strobe ignored whenever select one is high
// - output enable low drives data pins, high releases them
// - first read clock after deselect keeps data pins undriven
// - processor strobe loads address and seeds burst counter
// - both strobes low with select one low: processor strobe wins, controller strobe dropped
// - controller strobe loads address and seeds burst counter
// - burst order strap: low linear, high interleaved, held static
// - read data is the word addressed at the previous clock rise
// - counter wraps after four, staying in the aligned group of four
package sbspc_pkg;

   localparam int SBSPC_ADDR_W  = 17;
   localparam int SBSPC_HI_W    = 15;
   localparam int SBSPC_LOW_W   = 2;
   localparam int SBSPC_DEPTH   = 131072;
   localparam int SBSPC_LANES   = 4;
   localparam int SBSPC_LANE_DW = 8;

   localparam logic [1:0]  SBSPC_STEP_ZERO   = 2'h0;
   localparam logic [1:0]  SBSPC_STEP_ONE    = 2'h1;
   localparam logic [1:0]  SBSPC_LOW_ZERO    = 2'h0;
   localparam logic [14:0] SBSPC_HI_ZERO     = 15'h0;
   localparam logic        SBSPC_MODE_LINEAR = 1'h0;
   // strap idles at interleaved, as the pin is pulled up
   localparam logic        SBSPC_MODE_RESET  = 1'h1;
   localparam logic        SBSPC_OE_RESET_N  = 1'h1;

   typedef struct packed {
      logic       parity_io;
      logic [7:0] data;
   } sbspc_lane_t;

   typedef sbspc_lane_t [3:0] sbspc_word_t;

   localparam sbspc_word_t SBSPC_WORD_ZERO = 36'h0;

   typedef struct packed {
      logic processor_addr_strobe_n;
      logic controller_addr_strobe_n;
      logic chip_select_one_n;
      logic chip_select_two;
      logic chip_select_three_n;
      logic burst_step_n;
   } sbspc_strobe_t;

   typedef struct packed {
      logic       global_write_n;
      logic       byte_write_enable_n;
      logic [3:0] byte_lane_write_sel_n;
   } sbspc_write_t;

   typedef enum logic {
      SBSPC_ST_DESELECTED,
      SBSPC_ST_SELECTED
   } sbspc_state_t;

   function automatic logic sbspc_chip_selected(input sbspc_strobe_t s);
      return !s.chip_select_one_n && s.chip_select_two && !s.chip_select_three_n;
   endfunction

   function automatic logic sbspc_lane_write(input sbspc_write_t w, input int lane);
      return !w.global_write_n
         || (!w.byte_write_enable_n && !w.byte_lane_write_sel_n[lane]);
   endfunction

endpackage

// >>> verilog/sbspc_burst_seq.sv
// burst address low-bit sequencer
// assumes start bits and step count come unregistered from the caller's next-state logic
module sbspc_burst_seq (
   // burst position
   input  wire logic [1:0] start_low,
   input  wire logic [1:0] step,
   input  wire logic       interleaved,
   // resulting low address bits
   output logic      [1:0] burst_low
);
   import sbspc_pkg::*;

   always_comb begin
      // two-bit arithmetic wraps inside the aligned group of four
      if (interleaved != SBSPC_MODE_LINEAR) begin
         burst_low = start_low ^ step;
      end else begin
         burst_low = 2'(start_low + step);
      end
   end

endmodule // sbspc_burst_seq

// >>> verilog/sbspc_sram.sv
// synchronous flow-through burst sram core with its pin control
// assumes strobes, selects, writes and data in come from logic on clock;
// output enable and burst order strap are asynchronous pins
module sbspc_sram (
   // clock, reset, enable
   input  wire logic                              clock,
   input  wire logic                              reset_n,
   input  wire logic                              clock_en,
   // address and burst control
   input  wire logic [sbspc_pkg::SBSPC_ADDR_W-1:0] address,
   input  wire sbspc_pkg::sbspc_strobe_t          strobe,
   input  wire sbspc_pkg::sbspc_write_t           write,
   // asynchronous pins
   input  wire logic                              output_enable_n,
   input  wire logic                              burst_order,
   // data and parity pins
   input  wire sbspc_pkg::sbspc_word_t            dq_in,
   output sbspc_pkg::sbspc_word_t                 dq_out,
   output logic                                   dq_oe
);
   import sbspc_pkg::*;

   // ---- pin synchronisers
   logic oe_meta_n;
   logic oe_sync_n;
   logic mode_meta;
   logic mode_sync;
   logic next_oe_meta_n;
   logic next_oe_sync_n;
   logic next_mode_meta;
   logic next_mode_sync;

   always_comb begin
      next_oe_meta_n = oe_meta_n;
      next_oe_sync_n = oe_sync_n;
      next_mode_meta = mode_meta;
      next_mode_sync = mode_sync;
      if (clock_en) begin
         next_oe_meta_n = output_enable_n;
         next_oe_sync_n = oe_meta_n;
         // strap is caught after reset release, never under reset
         next_mode_meta = burst_order;
         next_mode_sync = mode_meta;
      end
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         oe_meta_n <= SBSPC_OE_RESET_N;
         oe_sync_n <= SBSPC_OE_RESET_N;
         mode_meta <= SBSPC_MODE_RESET;
         mode_sync <= SBSPC_MODE_RESET;
      end else begin
         oe_meta_n <= next_oe_meta_n;
         oe_sync_n <= next_oe_sync_n;
         mode_meta <= next_mode_meta;
         mode_sync <= next_mode_sync;
      end
   end

   // ---- address capture and burst counter
   sbspc_state_t      state;
   sbspc_state_t      next_state;
   logic [SBSPC_HI_W-1:0]  addr_hi;
   logic [SBSPC_HI_W-1:0]  next_addr_hi;
   logic [SBSPC_LOW_W-1:0] start_low;
   logic [SBSPC_LOW_W-1:0] next_start_low;
   logic [SBSPC_LOW_W-1:0] step;
   logic [SBSPC_LOW_W-1:0] next_step;
   logic              proc_start;
   logic              ctrl_start;
   logic              load;
   logic              selected;
   logic              first_read;

   always_comb begin
      proc_start     = !strobe.processor_addr_strobe_n
                       && !strobe.chip_select_one_n;
      ctrl_start     = !strobe.controller_addr_strobe_n && !proc_start;
      load           = proc_start || ctrl_start;
      selected       = sbspc_chip_selected(strobe);
      next_state     = state;
      next_addr_hi   = addr_hi;
      next_start_low = start_low;
      next_step      = step;
      first_read     = 1'h0;
      if (clock_en) begin
         if (load) begin
            // selects matter only here, never on burst cycles
            if (selected) begin
               next_state     = SBSPC_ST_SELECTED;
               next_addr_hi   = address[SBSPC_ADDR_W-1:SBSPC_LOW_W];
               next_start_low = address[SBSPC_LOW_W-1:0];
               next_step      = SBSPC_STEP_ZERO;
               first_read     = (state == SBSPC_ST_DESELECTED);
            end else begin
               next_state = SBSPC_ST_DESELECTED;
            end
         end else begin
            case (state)
               SBSPC_ST_SELECTED: begin
                  if (!strobe.burst_step_n) begin
                     next_step = 2'(step + SBSPC_STEP_ONE);
                  end
               end
               default: begin
                  next_step = step;
               end
            endcase
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         state     <= SBSPC_ST_DESELECTED;
         addr_hi   <= SBSPC_HI_ZERO;
         start_low <= SBSPC_LOW_ZERO;
         step      <= SBSPC_STEP_ZERO;
      end else begin
         state     <= next_state;
         addr_hi   <= next_addr_hi;
         start_low <= next_start_low;
         step      <= next_step;
      end
   end

   // address in effect at this edge, after any load or step
   logic [SBSPC_LOW_W-1:0]  burst_low;
   logic [SBSPC_ADDR_W-1:0] eff_addr;

   sbspc_burst_seq u_burst_seq (
      .start_low   (next_start_low),
      .step        (next_step),
      .interleaved (mode_sync),
      .burst_low   (burst_low)
   );

   assign eff_addr = {next_addr_hi, burst_low};

   // ---- storage, write lanes and read path
   sbspc_word_t mem_rd;
   logic [SBSPC_LANES-1:0] lane_wr;
   logic        write_ok;
   logic        any_write;
   sbspc_word_t next_dq_out;
   logic        next_dq_oe;

   // a processor strobe start is always a read; writes follow later
   assign write_ok  = clock_en && (next_state == SBSPC_ST_SELECTED) && !proc_start;
   assign any_write = |lane_wr;

   genvar g;
   generate
      for (g = 0; g < SBSPC_LANES; g++) begin : g_lane
         // one store per lane, so every store has a single writing process
         sbspc_lane_t lane_mem [0:SBSPC_DEPTH-1];

         assign lane_wr[g] = write_ok && sbspc_lane_write(write, g);
         assign mem_rd[g]  = lane_mem[eff_addr];

         always_ff @(posedge clock) begin
            if (reset_n && lane_wr[g]) begin
               lane_mem[eff_addr] <= dq_in[g];
            end
         end
      end
   endgenerate

   always_comb begin
      next_dq_out = dq_out;
      next_dq_oe  = dq_oe;
      if (clock_en) begin
         // flow-through: word of the address taken at this rise
         next_dq_out = mem_rd;
         // pin level is two edges late through the synchroniser
         next_dq_oe  = !oe_sync_n
                       && (next_state == SBSPC_ST_SELECTED)
                       && !any_write
                       && !first_read;
      end
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         dq_out <= SBSPC_WORD_ZERO;
         dq_oe  <= 1'h0;
      end else begin
         dq_out <= next_dq_out;
         dq_oe  <= next_dq_oe;
      end
   end

   // ---- checks
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!reset_n);

   a_deselect_on_load: assert property (
      clock_en && load && !sbspc_chip_selected(strobe)
      |=> state == SBSPC_ST_DESELECTED)
      else $error("bad select combination did not deselect");

   a_proc_strobe_ignored: assert property (
      clock_en && strobe.chip_select_one_n && !strobe.processor_addr_strobe_n
      && strobe.controller_addr_strobe_n
      |=> $stable(addr_hi) && $stable(start_low) && $stable(state))
      else $error("processor strobe acted with select one high");

   a_proc_addr_capture: assert property (
      clock_en && !strobe.processor_addr_strobe_n && sbspc_chip_selected(strobe)
      |=> addr_hi == $past(address[SBSPC_ADDR_W-1:SBSPC_LOW_W])
          && start_low == $past(address[SBSPC_LOW_W-1:0])
          && step == SBSPC_STEP_ZERO)
      else $error("processor strobe did not capture address");

   a_ctrl_addr_capture: assert property (
      clock_en && strobe.processor_addr_strobe_n
      && !strobe.controller_addr_strobe_n && sbspc_chip_selected(strobe)
      |=> start_low == $past(address[SBSPC_LOW_W-1:0])
          && state == SBSPC_ST_SELECTED && step == SBSPC_STEP_ZERO)
      else $error("controller strobe did not capture address");

   a_strobe_priority: assert property (
      clock_en && !strobe.processor_addr_strobe_n
      && !strobe.controller_addr_strobe_n && !strobe.chip_select_one_n
      |-> proc_start && !ctrl_start && !any_write)
      else $error("controller strobe acted beside processor strobe");

   a_burst_step_wrap: assert property (
      clock_en && !load && state == SBSPC_ST_SELECTED && !strobe.burst_step_n
      |=> step == 2'($past(step) + SBSPC_STEP_ONE))
      else $error("burst counter did not advance");

   a_selects_ignored: assert property (
      clock_en && !load ##1 clock_en && !load
      |-> $stable(state) && $stable(addr_hi))
      else $error("chip selects changed state during a burst");

   a_first_read_mask: assert property (
      clock_en && load && sbspc_chip_selected(strobe)
      && state == SBSPC_ST_DESELECTED
      |=> !dq_oe)
      else $error("data driven on first read after deselect");

   a_oe_release: assert property (
      clock_en && oe_sync_n |=> !dq_oe)
      else $error("data driven with output enable high");

   a_global_write: assert property (
      write_ok && !write.global_write_n |-> &lane_wr)
      else $error("global write missed a lane");

   a_interleave_order: assert property (
      mode_sync != SBSPC_MODE_LINEAR |-> burst_low == (next_start_low ^ next_step))
      else $error("interleaved burst address wrong");

   a_ctrl_hi_capture: assert property (
      clock_en && strobe.processor_addr_strobe_n
      && !strobe.controller_addr_strobe_n && sbspc_chip_selected(strobe)
      |=> addr_hi == $past(address[SBSPC_ADDR_W-1:SBSPC_LOW_W]))
      else $error("controller strobe did not capture upper address");

   a_proc_load_read: assert property (
      clock_en && proc_start |-> lane_wr == '0)
      else $error("processor strobe start wrote the array");

   a_byte_lane_sel: assert property (
      write_ok && write.global_write_n && !write.byte_write_enable_n
      |-> lane_wr == ~write.byte_lane_write_sel_n)
      else $error("byte write lanes differ from lane selects");

   a_no_write_qual: assert property (
      write.global_write_n && write.byte_write_enable_n |-> lane_wr == '0)
      else $error("lane written without a write enable");

   a_deselect_no_write: assert property (
      clock_en && !load && state == SBSPC_ST_DESELECTED |-> lane_wr == '0)
      else $error("deselected device wrote the array");

   a_step_hold: assert property (
      clock_en && !load && strobe.burst_step_n |=> $stable(step))
      else $error("burst counter moved without burst step");

   a_counter_wrap: assert property (
      clock_en && !load && state == SBSPC_ST_SELECTED && !strobe.burst_step_n
      && step == ~SBSPC_STEP_ZERO
      |=> step == SBSPC_STEP_ZERO)
      else $error("burst counter did not wrap after four");

   a_burst_group: assert property (
      clock_en && !load |-> eff_addr[SBSPC_ADDR_W-1:SBSPC_LOW_W] == addr_hi)
      else $error("burst left its aligned group of four");

   a_burst_start: assert property (
      next_step == SBSPC_STEP_ZERO |-> burst_low == next_start_low)
      else $error("burst start address differs from loaded bits");

   a_oe_drive: assert property (
      clock_en && !oe_sync_n && load && sbspc_chip_selected(strobe)
      && state == SBSPC_ST_SELECTED && !any_write
      |=> dq_oe)
      else $error("data not driven with output enable low");

endmodule // sbspc_sram

// >>> sim/sbspc_bus_model.sv
// bus master model: the cache controller side of the burst sram
// assumes put is called just after a rising clock edge of the shared clock
module sbspc_bus_model (
   // bus toward the sram
   output logic [sbspc_pkg::SBSPC_ADDR_W-1:0] address,
   output sbspc_pkg::sbspc_strobe_t          strobe,
   output sbspc_pkg::sbspc_write_t           write,
   output sbspc_pkg::sbspc_word_t            dq_in
);
   timeunit 1ns;
   timeprecision 1ps;
   import sbspc_pkg::*;

   initial begin
      address = 17'h0;
      strobe  = 6'h35;
      write   = 6'h3f;
      dq_in   = 36'h0;
   end

   task automatic put(input logic [16:0] a, input sbspc_strobe_t s, input sbspc_write_t w,
                      input sbspc_word_t d);
      address <= a;
      strobe  <= s;
      write   <= w;
      // released lines flip, so a stale word can never pass for a read
      if (w.global_write_n && w.byte_write_enable_n)
         dq_in <= ~dq_in;
      else
         dq_in <= d;
   endtask
endmodule // sbspc_bus_model

// >>> sim/sbspc_bench.sv
// self-checking bench of the burst sram pin control block
// assumes one 125 mhz clock; the bus model plays the cache controller
module sync_burst_sram_pin_control_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import sbspc_pkg::*;

   logic          clock;
   logic          reset_n;
   logic          clock_en;
   logic          output_enable_n;
   logic          burst_order;
   logic [16:0]   address;
   sbspc_strobe_t strobe;
   sbspc_write_t  write;
   sbspc_word_t   dq_in;
   sbspc_word_t   dq_out;
   logic          dq_oe;
   int            failures = 0;
   int            checks_done = 0;
   int            oe_quiet;
   logic [31:0]   seed = 32'h93c31b87;
   sbspc_word_t   mem [int];
   sbspc_word_t   e_out;
   logic [14:0]   hi;
   logic [1:0]    start;
   logic [1:0]    step;
   logic          sel;
   logic          e_ok;
   logic          e_oe;
   logic          oe_ok;
   logic [28:0]   corner [13] = '{{17'h08002, 6'h05, 6'h1f}, {17'h0, 6'h34, 6'h3f},
      {17'h0, 6'h34, 6'h3f}, {17'h0, 6'h34, 6'h3f}, {17'h0, 6'h34, 6'h3f},
      {17'h0, 6'h34, 6'h3f}, {17'h0, 6'h1d, 6'h3f}, {17'h0, 6'h38, 6'h3f},
      {17'h10003, 6'h24, 6'h2e}, {17'h10003, 6'h25, 6'h3f}, {17'h0, 6'h2a, 6'h1f},
      {17'h10003, 6'h15, 6'h3f}, {17'h0, 6'h35, 6'h3f}};

   sbspc_sram dut_u (.clock, .reset_n, .clock_en, .address, .strobe, .write,
      .output_enable_n, .burst_order, .dq_in, .dq_out, .dq_oe);
   sbspc_bus_model bus_u (.address, .strobe, .write, .dq_in);

   initial begin
      clock = 1'h0;
      forever #4 clock = ~clock;
   end

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic chk(input string what, input logic [35:0] exp, input logic [35:0] got);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // one bus cycle: drive, judge the previous cycle, then predict this one
   task automatic cyc(input logic [16:0] a, input sbspc_strobe_t s, input sbspc_write_t w,
                      input logic ce, input logic tog);
      logic [63:0] r;
      sbspc_word_t d;
      sbspc_word_t nw;
      logic [3:0]  m;
      logic        pld;
      logic [16:0] ea;
      r = {rnd(), rnd()};
      d = r[35:0];
      @(posedge clock);
      bus_u.put(a, s, w, d);
      clock_en <= ce;
      if (tog) begin
         output_enable_n <= ~output_enable_n;
         oe_quiet = -1;
      end
      #1;
      if (e_ok) chk("read word", e_out, dq_out);
      if (oe_ok) chk("drive enable", {35'h0, e_oe}, {35'h0, dq_oe});
      if (!ce) return;
      oe_quiet++;
      pld = !s.processor_addr_strobe_n && !s.chip_select_one_n;
      if (pld || !s.controller_addr_strobe_n) begin
         e_oe = sel;
         sel = !s.chip_select_one_n && s.chip_select_two && !s.chip_select_three_n;
         if (sel) {hi, start, step} = {a, 2'h0};
      end else begin
         e_oe = 1'h1;
         if (sel && !s.burst_step_n) step = step + 2'h1;
      end
      ea = {hi, burst_order ? start ^ step : start + step};
      e_ok = sel && mem.exists(ea);
      if (e_ok) e_out = mem[ea];
      nw = mem.exists(ea) ? mem[ea] : d;
      for (int i = 0; i < 4; i++) begin
         m[i] = sel && !pld && (!w.global_write_n
            || (!w.byte_write_enable_n && !w.byte_lane_write_sel_n[i]));
         if (m[i]) nw[i] = d[i];
      end
      // partial writes to unknown words stay unmodelled
      if (m != 4'h0 && (m == 4'hf || mem.exists(ea))) mem[ea] = nw;
      e_oe = e_oe && sel && m == 4'h0 && !output_enable_n;
      oe_ok = oe_quiet > 3;
   endtask

   task automatic test(input logic mode);
      logic [31:0]   r;
      sbspc_strobe_t s;
      sbspc_write_t  w;
      @(posedge clock);
      bus_u.put(17'h0, 6'h35, 6'h3f, 36'h0);
      reset_n <= 1'h0;
      burst_order <= mode;
      repeat (12) @(posedge clock);
      reset_n <= 1'h1;
      #1;
      chk("reset data", 36'h0, dq_out);
      chk("reset drive", 36'h0, {35'h0, dq_oe});
      {sel, e_ok, oe_ok, oe_quiet, hi, start, step} = '0;
      repeat (4) cyc(17'h0, 6'h35, 6'h3f, 1'h1, 1'h0);
      for (int k = 0; k < 16; k++)
         cyc({k[3:2], 13'h0, 2'h0}, k[1:0] == 2'h0 ? 6'h25 : 6'h34, 6'h1f, 1'h1, 1'h0);
      foreach (corner[j])
         cyc(corner[j][28:12], corner[j][11:6], corner[j][5:0], 1'h1, 1'h0);
      for (int n = 0; n < 600; n++) begin
         r = rnd();
         s = {r[0] | r[1], r[2] | r[3], r[6:4] == 3'h0 ? r[9:7] : 3'h2, r[10]};
         w = !s.processor_addr_strobe_n ? 6'h3f : {r[11] | r[12], r[13], r[17:14]};
         cyc({r[19:18], 13'h0, r[21:20]}, s, w, r[24:22] != 3'h0, r[29:25] == 5'h0);
      end
      cyc(17'h0, 6'h35, 6'h3f, 1'h1, 1'h0);
      $display("test with burst order %0d done", mode);
   endtask

   initial begin
      reset_n = 1'h0;
      clock_en = 1'h1;
      output_enable_n = 1'h0;
      burst_order = 1'h1;
      test(1'h1);
      test(1'h0);
      results();
   end

   // whole run is near 1300 cycles
   initial begin
      repeat (5000) @(posedge clock);
      failures++;
      results();
   end
endmodule // sync_burst_sram_pin_control_bench
